/* common/ssalu_defs.svh */
/*
 Constants for the subtract/swap ALU slice: widths, flag positions, reset values.
 Assumes inclusion by bare name from files that need them.
*/
`ifndef SSALU_DEFS_SVH
`define SSALU_DEFS_SVH
`define SSALU_DW 8
`define SSALU_ACC_RST 8'h00
`define SSALU_WDATA_RST 8'h00
`define SSALU_FLAG_C 0
`define SSALU_FLAG_HALF_CARRY 1
`define SSALU_FLAG_Z 2
`define SSALU_FLAG_OVERFLOW 3
`define SSALU_FLAGS_RST 4'h0
`endif

/* common/ssalu_pkg.sv */
/*
 Types for the subtract/swap ALU slice.
 Assumes ssalu_defs.svh is on the include path.
*/
`include "ssalu_defs.svh"
package ssalu_pkg;
  typedef enum logic [2:0] {
    SSALU_OP_NONE,
    SSALU_OP_SUB_TO_MEMORY,
    SSALU_OP_SUB_IMM,
    SSALU_OP_SWAP_MEM,
    SSALU_OP_NIBBLE_EXCHANGE_TO_ACC
  } ssalu_op_t;
  typedef logic [`SSALU_DW-1:0] ssalu_byte_t;
endpackage : ssalu_pkg

/* common/ssalu_sub_if.sv */
/*
 Interface carrying operands and results between the top and the subtractor.
 Assumes one clockless combinational connection.
*/
`timescale 1ns/100ps
interface ssalu_sub_if;
  import ssalu_pkg::*;
  ssalu_byte_t minuend;
  ssalu_byte_t subtrahend;
  ssalu_byte_t diff;
  logic carry;
  logic half_carry;
  logic zero;
  logic overflow;
  modport user (output minuend, output subtrahend, input diff, input carry, input half_carry, input zero,
    input overflow);
  modport unit (input minuend, input subtrahend, output diff, output carry, output half_carry, output zero,
    output overflow);
endinterface : ssalu_sub_if

/* hw/ssalu_subtractor.sv */
/*
 Combinational 8-bit subtractor with flag generation.
 Assumes operands are stable within the cycle they are used.
*/
`timescale 1ns/100ps
`include "ssalu_defs.svh"
module ssalu_subtractor (
  ssalu_sub_if.unit s
);
  import ssalu_pkg::*;
  logic [`SSALU_DW:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, s.minuend} + {1'b0, ~s.subtrahend} + 9'h001;
    low = {1'b0, s.minuend[3:0]} + {1'b0, ~s.subtrahend[3:0]} + 5'h01;
    s.diff = full[`SSALU_DW-1:0];
    // Carry is "no borrow": set when difference is zero or positive
    s.carry = full[`SSALU_DW]; // [RULE2]
    s.half_carry = low[4]; // [RULE7]
    s.zero = (full[`SSALU_DW-1:0] == 8'h00); // [RULE7]
    s.overflow = (s.minuend[7] != s.subtrahend[7]) && (full[7] != s.minuend[7]); // [RULE7]
  end
endmodule : ssalu_subtractor

/* hw/ssalu_top.sv */
/*
 Subtract and nibble-swap datapath slice of an 8-bit accumulator core.
 Assumes the decoder presents one op per cycle with the memory byte already read;
 the memory write port samples mem_wr_en/mem_wr_data one cycle after the op.
*/
// How it works
// [RULE1] A memory-destination subtract writes accumulator minus memory byte back to memory and updates all four flags.
// [RULE2] After a subtraction carry is 0 on a borrow and 1 when the difference is zero or positive.
// [RULE3] An immediate subtract puts accumulator minus the instruction constant into the accumulator, same carry rule.
// [RULE4] An in-place swap exchanges the two nibbles of the memory byte and writes it back.
// [RULE5] An accumulator-destination swap puts the nibble-exchanged memory byte into the accumulator.
// [RULE6] An accumulator-destination swap writes no memory and changes no flags.
// [RULE7] Subtraction sets zero on a zero result, overflow on signed overflow, half carry when bit 3 does not borrow.
`timescale 1ns/100ps
`include "ssalu_defs.svh"
module ssalu_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Decoded instruction and operands
  input wire ssalu_pkg::ssalu_op_t op,
  input wire ssalu_pkg::ssalu_byte_t mem_rd_data,
  input wire ssalu_pkg::ssalu_byte_t imm_data,
  // Memory write-back
  output logic mem_wr_en,
  output ssalu_pkg::ssalu_byte_t mem_wr_data,
  // Architectural state
  output ssalu_pkg::ssalu_byte_t accumulator,
  output logic overflow_flag,
  output logic zero_flag,
  output logic half_carry_flag,
  output logic carry_flag
);
  import ssalu_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  // Nibble exchange shared by the in-place and the accumulator swap
  function automatic ssalu_byte_t swap_nib(input ssalu_byte_t b);
    swap_nib = {b[3:0], b[7:4]};
  endfunction : swap_nib

  // Both subtract forms update the four flags; nothing else touches them
  function automatic logic is_sub_op(input ssalu_op_t o);
    is_sub_op = (o == SSALU_OP_SUB_TO_MEMORY) || (o == SSALU_OP_SUB_IMM);
  endfunction : is_sub_op

  // Ops whose result goes back to the addressed memory byte
  function automatic logic is_mem_dest_op(input ssalu_op_t o);
    is_mem_dest_op = (o == SSALU_OP_SUB_TO_MEMORY) || (o == SSALU_OP_SWAP_MEM);
  endfunction : is_mem_dest_op

  // Places each flag at its bit, so the flag order lives in the header alone
  function automatic logic [3:0] pack_flags(input logic ovf, input logic zf, input logic hcf, input logic cf);
    pack_flags = `SSALU_FLAGS_RST;
    pack_flags[`SSALU_FLAG_OVERFLOW] = ovf;
    pack_flags[`SSALU_FLAG_Z] = zf;
    pack_flags[`SSALU_FLAG_HALF_CARRY] = hcf;
    pack_flags[`SSALU_FLAG_C] = cf;
  endfunction : pack_flags

  // ****************************************
  // State and subtractor
  // ****************************************
  ssalu_byte_t acc_reg, acc_next;
  ssalu_byte_t wdata_reg, wdata_next;
  logic wen_reg, wen_next;
  logic [3:0] flags_reg, flags_next;

  ssalu_sub_if sub_bus ();
  ssalu_subtractor u_sub (
    .s(sub_bus.unit)
  );

  // One subtractor serves both subtract forms; only the subtrahend is muxed
  assign sub_bus.minuend = acc_reg;
  assign sub_bus.subtrahend = (op == SSALU_OP_SUB_IMM) ? imm_data : mem_rd_data;

  // ****************************************
  // Accumulator
  // ****************************************
  always_comb begin
    acc_next = acc_reg;
    unique case (op)
      SSALU_OP_SUB_IMM: begin
        acc_next = sub_bus.diff; // [RULE3]
      end
      SSALU_OP_NIBBLE_EXCHANGE_TO_ACC: begin
        acc_next = swap_nib(mem_rd_data); // [RULE5]
      end
      SSALU_OP_NONE, SSALU_OP_SUB_TO_MEMORY, SSALU_OP_SWAP_MEM: begin
        // A no-op or a memory-destination op leaves the accumulator as it was
      end
      default: begin
        // Unused op codes idle
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= `SSALU_ACC_RST;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ****************************************
  // Memory write port
  // ****************************************
  // The write lands one cycle after the op; the memory must apply it before it rereads the byte
  always_comb begin
    wen_next = is_mem_dest_op(op); // [RULE1] [RULE4] [RULE6]
    wdata_next = wdata_reg;
    unique case (op)
      SSALU_OP_SUB_TO_MEMORY: begin
        wdata_next = sub_bus.diff; // [RULE1]
      end
      SSALU_OP_SWAP_MEM: begin
        wdata_next = swap_nib(mem_rd_data); // [RULE4]
      end
      SSALU_OP_NONE, SSALU_OP_SUB_IMM, SSALU_OP_NIBBLE_EXCHANGE_TO_ACC: begin
        // Holding the last value keeps the data lines quiet between writes
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wen_reg <= 1'b0;
      wdata_reg <= `SSALU_WDATA_RST;
    end else begin
      wen_reg <= wen_next;
      wdata_reg <= wdata_next;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Swaps in either form leave the flags alone
  always_comb begin
    flags_next = flags_reg; // [RULE6]
    if (is_sub_op(op)) begin
      flags_next = pack_flags(sub_bus.overflow, sub_bus.zero, sub_bus.half_carry, sub_bus.carry); // [RULE2] [RULE7]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= `SSALU_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mem_wr_en = wen_reg;
  assign mem_wr_data = wdata_reg;
  assign accumulator = acc_reg;
  assign overflow_flag = flags_reg[`SSALU_FLAG_OVERFLOW];
  assign zero_flag = flags_reg[`SSALU_FLAG_Z];
  assign half_carry_flag = flags_reg[`SSALU_FLAG_HALF_CARRY];
  assign carry_flag = flags_reg[`SSALU_FLAG_C];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_sub_mem_writeback: assert property ( // [RULE1]
    op == SSALU_OP_SUB_TO_MEMORY |=> mem_wr_en && mem_wr_data == 8'($past(accumulator) - $past(mem_rd_data)))
    else $error("memory subtract result wrong");
  a_sub_mem_keeps_acc: assert property ( // [RULE1]
    op == SSALU_OP_SUB_TO_MEMORY |=> $stable(accumulator) && zero_flag == (mem_wr_data == 8'h00))
    else $error("memory subtract side effect or zero flag wrong");
  a_carry_borrow: assert property ( // [RULE2]
    op == SSALU_OP_SUB_TO_MEMORY |=>
    carry_flag == ($past(accumulator) >= $past(mem_rd_data)))
    else $error("memory subtract carry flag wrong");
  a_carry_borrow_imm: assert property ( // [RULE2]
    op == SSALU_OP_SUB_IMM |=>
    carry_flag == ($past(accumulator) >= $past(imm_data)))
    else $error("immediate subtract carry flag wrong");
  a_sub_imm_acc: assert property ( // [RULE3]
    op == SSALU_OP_SUB_IMM |=> !mem_wr_en && accumulator == 8'($past(accumulator) - $past(imm_data)))
    else $error("immediate subtract result wrong");
  a_swap_mem: assert property ( // [RULE4]
    op == SSALU_OP_SWAP_MEM |=> mem_wr_en && mem_wr_data == {$past(mem_rd_data[3:0]), $past(mem_rd_data[7:4])}
    && $stable(accumulator))
    else $error("in-place swap wrong");
  a_swap_mem_quiet: assert property ( // [RULE4]
    op == SSALU_OP_SWAP_MEM |=> $stable(flags_reg))
    else $error("in-place swap changed a flag");
  a_swap_acc: assert property ( // [RULE5]
    op == SSALU_OP_NIBBLE_EXCHANGE_TO_ACC |=> accumulator == {$past(mem_rd_data[3:0]), $past(mem_rd_data[7:4])})
    else $error("accumulator swap result wrong");
  a_swap_acc_quiet: assert property ( // [RULE6]
    op == SSALU_OP_NIBBLE_EXCHANGE_TO_ACC |=> !mem_wr_en && $stable(mem_wr_data) && $stable(carry_flag)
    && $stable(zero_flag) && $stable(overflow_flag) && $stable(half_carry_flag))
    else $error("accumulator swap side effect");
  a_write_source: assert property ( // [RULE6]
    mem_wr_en |-> $past(op) == SSALU_OP_SUB_TO_MEMORY || $past(op) == SSALU_OP_SWAP_MEM)
    else $error("memory written by a non-memory op");
  a_zero_flag: assert property ( // [RULE7]
    op == SSALU_OP_SUB_IMM |=> zero_flag == (accumulator == 8'h00))
    else $error("zero flag wrong");
  a_half_carry: assert property ( // [RULE7]
    op == SSALU_OP_SUB_IMM |=> half_carry_flag == ($past(accumulator[3:0]) >= $past(imm_data[3:0])))
    else $error("half carry flag wrong");
  a_half_carry_mem: assert property ( // [RULE7]
    op == SSALU_OP_SUB_TO_MEMORY |=> half_carry_flag == ($past(accumulator[3:0]) >= $past(mem_rd_data[3:0])))
    else $error("memory subtract half carry flag wrong");
  a_overflow: assert property ( // [RULE7]
    op == SSALU_OP_SUB_IMM |=> overflow_flag ==
    (($past(accumulator[7]) != $past(imm_data[7])) && (accumulator[7] != $past(accumulator[7]))))
    else $error("overflow flag wrong");
  a_overflow_mem: assert property ( // [RULE7]
    op == SSALU_OP_SUB_TO_MEMORY |=> overflow_flag ==
    (($past(accumulator[7]) != $past(mem_rd_data[7])) && (mem_wr_data[7] != $past(accumulator[7]))))
    else $error("memory subtract overflow flag wrong");

  c_sub_mem_borrow: cover property (op == SSALU_OP_SUB_TO_MEMORY ##1 !carry_flag);
  c_sub_imm_zero: cover property (op == SSALU_OP_SUB_IMM ##1 zero_flag);
  c_sub_imm_overflow: cover property (op == SSALU_OP_SUB_IMM ##1 overflow_flag);
  c_swap_mem: cover property (op == SSALU_OP_SWAP_MEM ##1 mem_wr_en);
  c_swap_acc_after_sub: cover property (op == SSALU_OP_SUB_IMM ##1 op == SSALU_OP_NIBBLE_EXCHANGE_TO_ACC);
endmodule : ssalu_top

/* bench/ssalu_top_bench.sv */
/*
 Self-checking bench for ssalu_top: drives ops and operands straight onto the ports.
 Assumes ssalu_pkg and the design files are compiled first.
*/
`timescale 1ns/100ps
module ssalu_top_bench;
  import ssalu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  ssalu_op_t op = SSALU_OP_NONE;
  ssalu_byte_t mem_rd_data = 8'h00;
  ssalu_byte_t imm_data = 8'h00;
  logic mem_wr_en;
  ssalu_byte_t mem_wr_data;
  ssalu_byte_t accumulator;
  logic overflow_flag;
  logic zero_flag;
  logic half_carry_flag;
  logic carry_flag;
  ssalu_byte_t acc_exp = 8'h00;
  logic [3:0] flg_exp = 4'h0;
  int num_errors = 0;
  int num_checks = 0;
  ssalu_op_t ops[11] = '{SSALU_OP_NIBBLE_EXCHANGE_TO_ACC, SSALU_OP_SUB_IMM, SSALU_OP_SUB_IMM,
    SSALU_OP_SUB_TO_MEMORY, SSALU_OP_SUB_IMM, SSALU_OP_SWAP_MEM, SSALU_OP_NIBBLE_EXCHANGE_TO_ACC,
    SSALU_OP_SUB_TO_MEMORY, SSALU_OP_SUB_IMM, SSALU_OP_SUB_IMM, SSALU_OP_NONE};
  ssalu_byte_t mems[11] = '{8'h3a, 8'h55, 8'haa, 8'h7f, 8'h11, 8'hc5, 8'h12, 8'h93, 8'h00, 8'h99, 8'h66};
  ssalu_byte_t imms[11] = '{8'hff, 8'h23, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'hff, 8'h0f, 8'hf2, 8'h01};

  always #50 ref_clk = ~ref_clk;

  ssalu_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .op(op), .mem_rd_data(mem_rd_data), .imm_data(imm_data),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .accumulator(accumulator),
    .overflow_flag(overflow_flag), .zero_flag(zero_flag), .half_carry_flag(half_carry_flag),
    .carry_flag(carry_flag));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Op driver: op stays applied, so calls run back to back
  // ****************************************
  task automatic run_op(input ssalu_op_t o, input ssalu_byte_t m, input ssalu_byte_t i);
    ssalu_byte_t a;
    ssalu_byte_t b;
    ssalu_byte_t d;
    logic is_sub;
    logic wr;
    logic [7:0] flg_seen;
    a = acc_exp;
    b = (o == SSALU_OP_SUB_IMM) ? i : m;
    d = a - b;
    is_sub = (o == SSALU_OP_SUB_TO_MEMORY) || (o == SSALU_OP_SUB_IMM);
    wr = (o == SSALU_OP_SUB_TO_MEMORY) || (o == SSALU_OP_SWAP_MEM);
    op = o;
    mem_rd_data = m;
    imm_data = i;
    @(posedge ref_clk);
    #1;
    if (is_sub) flg_exp = {(a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    if (o == SSALU_OP_SUB_IMM) acc_exp = d;
    if (o == SSALU_OP_NIBBLE_EXCHANGE_TO_ACC) acc_exp = {m[3:0], m[7:4]};
    chk("mem_wr_en", {7'h00, mem_wr_en}, {7'h00, wr});
    if (wr) chk("mem_wr_data", mem_wr_data, (o == SSALU_OP_SWAP_MEM) ? {m[3:0], m[7:4]} : d);
    chk("accumulator", accumulator, acc_exp);
    flg_seen = {4'h0, overflow_flag, zero_flag, half_carry_flag, carry_flag};
    chk("flags", flg_seen, {4'h0, flg_exp});
  endtask : run_op

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    for (int k = 0; k < 11; k++) run_op(ops[k], mems[k], imms[k]);
    // Unused op codes must idle
    run_op(ssalu_op_t'(3'h7), 8'h5a, 8'h3c);
    // Reset in mid-run clears the state
    run_op(SSALU_OP_SUB_IMM, 8'h00, 8'h01);
    rst_b = 1'b0;
    #1;
    acc_exp = 8'h00;
    flg_exp = 4'h0;
    chk("rst_acc", accumulator, acc_exp);
    chk("rst_wr_en", {7'h00, mem_wr_en}, 8'h00);
    @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    run_op(SSALU_OP_SUB_IMM, 8'h00, 8'h00);
    run_op(SSALU_OP_NIBBLE_EXCHANGE_TO_ACC, 8'h4b, 8'h00);
    run_op(SSALU_OP_NONE, 8'h00, 8'h00);
    tally_and_finish();
  end
endmodule : ssalu_top_bench
